// File: common/pcp_pkg.sv
package pcp_pkg;
   localparam int DATA_W             = 8;
   localparam int MODE_W             = 3;
   localparam logic [2:0] MODE_MS_A  = 3'h0;
   localparam logic [2:0] MODE_MS_B  = 3'h4;
   localparam int CLK_PERIOD_NS      = 25;
   localparam int CFG_DIV            = 4;
   localparam logic [7:0] BUSY_EVERY = 8'h04;
   localparam int BUSY_CYCLES        = 2;
   localparam logic [7:0] FILL_BYTE  = 8'hFF;
endpackage

// File: common/pcp_if.sv
`timescale 1ns/1ps
interface pcp_if;
   logic       cfg_clk;
   logic       sel_n;
   logic       wr_n;
   logic [7:0] host_d;
   logic       host_oe;
   logic [7:0] dev_d;
   logic       dev_oe;
   logic       busy;
   modport device (input cfg_clk, input sel_n, input wr_n, input host_d,
                   input host_oe, output dev_d, output dev_oe, output busy);
   modport host (output cfg_clk, output sel_n, output wr_n, output host_d,
                 output host_oe, input dev_d, input dev_oe, input busy);
endinterface

// File: hw/pcp_device.sv
// Operation
// RL1: Take one byte per transfer, drive busy
// RL2: Host supplies bytes, clock, select, strobe
// RL3: Data held while busy high
// RL4: Selected with strobe high gives readback
// RL5: After load, release pins or keep readback
// RL6: Mode pins 000 or 100 mean master-serial
// RL7: Host selects shared devices one at time
// RL8: Packet may span several select periods
// RL9: Strobe change under select starts abort
// RL10: Host drives byte after strobes low
// RL11: Host drivers off during readback
// RL12: One select at most while strobe high
// RL13: No configuration while restart input low
// RL14: Sampling and busy follow config clock
// RL15: Drive bus only in readback window
`timescale 1ns/1ps
module pcp_device #(
   parameter int PKT_LEN = 16
) (
   input  wire logic       CORE_CLK_IN,
   input  wire logic       RST_IN,
   pcp_if.device           port,
   input  wire logic       RESTART_N_IN,
   input  wire logic [2:0] MODE_SELECT_PINS_IN,
   input  wire logic       RETAIN_IN,
   input  wire logic [7:0] RB_DATA_IN,
   output logic            MASTER_SERIAL_OUT,
   output logic            BYTE_VALID_OUT,
   output logic [7:0]      BYTE_OUT,
   output logic            ABORT_OUT,
   output logic            DONE_OUT,
   output logic            PORT_ACTIVE_OUT
);
   typedef enum logic [1:0] {
      ST_WAIT = 2'b00,
      ST_LOAD = 2'b01,
      ST_DONE = 2'b10
   } st_e;
   st_e        st_q;
   st_e        st_d;
   logic [2:0] clk_s_q;
   logic [2:0] sel_s_q;
   logic [2:0] wr_s_q;
   logic [2:0] rst_s_q;
   logic [7:0] d_s1_q;
   logic [7:0] d_s2_q;
   logic [2:0] mode_s1_q;
   logic [2:0] mode_s2_q;
   logic       ms_q;
   logic       wr_prev_q;
   logic       sel_prev_q;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [1:0] busy_q;
   logic [1:0] busy_d;
   logic [7:0] byte_q;
   logic       vld_q;
   logic       abort_q;
   logic [7:0] rb_q;

   function automatic logic is_master_serial(input logic [2:0] m);
      return (m == pcp_pkg::MODE_MS_A) | (m == pcp_pkg::MODE_MS_B);
   endfunction

   function automatic logic group_end(input logic [7:0] c);
      return (c & (pcp_pkg::BUSY_EVERY - 8'h01)) ==
             (pcp_pkg::BUSY_EVERY - 8'h01);
   endfunction

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         clk_s_q <= 3'h0;
         sel_s_q <= 3'h7;
         wr_s_q  <= 3'h7;
         rst_s_q <= 3'h0;
         d_s1_q  <= 8'h00;
         d_s2_q  <= 8'h00;
      end else begin
         clk_s_q <= {clk_s_q[1:0], port.cfg_clk};
         sel_s_q <= {sel_s_q[1:0], port.sel_n};
         wr_s_q  <= {wr_s_q[1:0], port.wr_n};
         rst_s_q <= {rst_s_q[1:0], RESTART_N_IN};
         d_s1_q  <= port.host_d;
         d_s2_q  <= d_s1_q;
      end
   end

   // Two-flop capture of the mode pins
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         mode_s1_q <= 3'h0;
         mode_s2_q <= 3'h0;
         ms_q      <= 1'b0;
      end else begin
         mode_s1_q <= MODE_SELECT_PINS_IN;
         mode_s2_q <= mode_s1_q;
         ms_q      <= is_master_serial(mode_s2_q); // [RL6]
      end
   end

   wire rise       = clk_s_q[1] & ~clk_s_q[2]; // [RL14]
   wire sel        = ~sel_s_q[1];
   wire wr         = ~wr_s_q[1];
   wire restart    = ~rst_s_q[1];
   wire in_load    = (st_q == ST_LOAD);
   wire retained   = (st_q == ST_DONE) & RETAIN_IN; // [RL5]
   wire strobe_chg = rise & sel & sel_prev_q & (wr != wr_prev_q); // [RL9]
   wire take       = rise & sel & wr & in_load & (busy_q == 2'h0) &
                     ~strobe_chg; // [RL1] [RL3]
   wire last       = (cnt_q == 8'(PKT_LEN - 1));
   wire rb_win     = sel & ~wr & (in_load | retained); // [RL4] [RL15]

   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_WAIT: begin
            if (!restart) st_d = ST_LOAD; // [RL13]
         end
         ST_LOAD: begin
            if (restart) st_d = ST_WAIT; // [RL13]
            else if (take && last) st_d = ST_DONE;
         end
         ST_DONE: begin
            if (restart) st_d = ST_WAIT;
         end
         default: st_d = ST_WAIT;
      endcase
   end

   // Next count and busy values
   always_comb begin
      cnt_d = cnt_q;
      if (take) begin
         // Count survives deselect: packets span selects [RL8]
         cnt_d = last ? 8'h00 : cnt_q + 8'h01;
      end
      if (strobe_chg || !in_load) begin
         cnt_d = 8'h00; // [RL9]
      end
   end
   always_comb begin
      busy_d = busy_q;
      if (rise && busy_q != 2'h0) begin
         busy_d = busy_q - 2'h1; // [RL14]
      end
      if (take && group_end(cnt_q)) begin
         busy_d = 2'(pcp_pkg::BUSY_CYCLES); // [RL1]
      end
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         st_q <= ST_WAIT;
      end else begin
         st_q <= st_d;
      end
   end
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         cnt_q  <= 8'h00;
         busy_q <= 2'h0;
      end else begin
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
      end
   end
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         wr_prev_q  <= 1'b0;
         sel_prev_q <= 1'b0;
      end else if (rise) begin
         wr_prev_q  <= wr;
         sel_prev_q <= sel;
      end
   end
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         byte_q <= 8'h00;
         vld_q  <= 1'b0;
      end else begin
         vld_q <= take;
         if (take) begin
            byte_q <= d_s2_q; // [RL1]
         end
      end
   end
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         abort_q <= 1'b0;
      end else begin
         abort_q <= strobe_chg; // [RL9]
      end
   end
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         rb_q <= 8'h00;
      end else if (rise && rb_win) begin
         rb_q <= RB_DATA_IN; // [RL4]
      end
   end

   assign port.busy         = busy_q != 2'h0; // [RL1]
   assign port.dev_d        = rb_q;
   assign port.dev_oe       = rb_win; // [RL15] [RL5]
   assign MASTER_SERIAL_OUT = ms_q; // [RL6]
   assign BYTE_VALID_OUT    = vld_q;
   assign BYTE_OUT          = byte_q;
   assign ABORT_OUT         = abort_q;
   assign DONE_OUT          = st_q == ST_DONE;
   assign PORT_ACTIVE_OUT   = in_load | retained; // [RL5]
endmodule // pcp_device

// File: hw/pcp_host.sv
`timescale 1ns/1ps
module pcp_host (
   input  wire logic       CORE_CLK_IN,
   input  wire logic       RST_IN,
   pcp_if.host             port,
   input  wire logic       WR_VALID_IN,
   input  wire logic [7:0] WR_DATA_IN,
   output logic            WR_READY_OUT,
   input  wire logic       RD_REQ_IN,
   output logic            RD_VALID_OUT,
   output logic [7:0]      RD_DATA_OUT
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_WR   = 2'b01,
      H_RD   = 2'b10,
      H_END  = 2'b11
   } hst_e;
   hst_e       st_q;
   logic [1:0] div_q;
   logic       clk_q;
   logic [7:0] d_q;
   logic [7:0] rd_q;
   logic       rv_q;
   logic       rd_half_q;
   logic [1:0] b_s_q;
   logic [7:0] rb_s1_q, rb_s2_q;
   wire fall   = (div_q == 2'(pcp_pkg::CFG_DIV - 1)) & clk_q;
   wire busy   = b_s_q[1];
   always_ff @(posedge CORE_CLK_IN) begin
      if (RST_IN) begin
         div_q   <= 2'h0;
         clk_q   <= 1'b0;
         st_q    <= H_IDLE;
         d_q     <= 8'h00;
         rd_q    <= 8'h00;
         rv_q    <= 1'b0;
         b_s_q   <= 2'h0;
         rd_half_q <= 1'b0;
         rb_s1_q <= 8'h00;
         rb_s2_q <= 8'h00;
      end else begin
         b_s_q   <= {b_s_q[0], port.busy};
         rb_s1_q <= port.dev_d;
         rb_s2_q <= rb_s1_q;
         div_q   <= div_q + 2'h1;
         rv_q    <= 1'b0;
         if (div_q == 2'(pcp_pkg::CFG_DIV - 1)) clk_q <= ~clk_q;
         if (fall) begin
            case (st_q)
               H_IDLE: begin
                  if (WR_VALID_IN) begin
                     st_q <= H_WR;
                     d_q  <= WR_DATA_IN;
                  end else if (RD_REQ_IN) begin
                     st_q <= H_RD;
                  end
               end
               H_WR: begin
                  // Byte is held while busy stays high [RL3]
                  if (!busy) st_q <= H_END;
               end
               H_RD: begin
                  // Second fall: readback byte has crossed the sync
                  if (rd_half_q) begin
                     rd_q <= rb_s2_q; // [RL4]
                     rv_q <= 1'b1;
                     st_q <= H_END;
                  end
                  rd_half_q <= ~rd_half_q;
               end
               H_END: st_q <= H_IDLE;
               default: st_q <= H_IDLE;
            endcase
         end
      end
   end
   assign port.cfg_clk = clk_q; // [RL2] [RL14]
   assign port.sel_n   = ~((st_q == H_WR) | (st_q == H_RD)); // [RL2]
   assign port.wr_n    = ~(st_q == H_WR); // [RL2] [RL9]
   assign port.host_d  = d_q; // [RL3]
   assign port.host_oe = st_q == H_WR; // [RL10] [RL11]
   assign WR_READY_OUT = fall & (st_q == H_IDLE);
   assign RD_VALID_OUT = rv_q;
   assign RD_DATA_OUT  = rd_q;
endmodule // pcp_host

// File: test/pcp_monitor.sv
`timescale 1ns/1ps
module pcp_monitor (
   input wire logic       CORE_CLK_IN,
   input wire logic       RST_IN,
   input wire logic       cfg_clk,
   input wire logic       sel_n,
   input wire logic       wr_n,
   input wire logic [7:0] host_d,
   input wire logic       host_oe,
   input wire logic       dev_oe,
   input wire logic       busy
);
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (RST_IN);
   sequence s_busy_hold;
      busy [*8] ##[1:40] !busy;
   endsequence
   sequence s_wr_sel;
      !sel_n && !wr_n;
   endsequence
   a_no_bus_fight: assert property (!(host_oe && dev_oe))
      else $error("both ends drive bus");
   a_readback_start: assert property ($rose(dev_oe) |-> !sel_n && wr_n)
      else $error("readback outside window");
   a_byte_hold: assert property ((s_wr_sel ##0 busy) |=> $stable(host_d))
      else $error("byte moved while busy");
   a_busy_hold: assert property ($rose(busy) |=> s_busy_hold)
      else $error("busy length wrong");
   a_strobe_edge: assert property ($changed({sel_n, wr_n}) |-> $fell(cfg_clk))
      else $error("strobe off clock");
   a_host_oe_write: assert property (host_oe |-> s_wr_sel)
      else $error("host drives outside write");
   a_strobe_steady: assert property (!sel_n && !$past(sel_n) |-> $stable(wr_n))
      else $error("strobe changed under select");
   a_write_drive: assert property ($fell(sel_n) && !wr_n |-> host_oe)
      else $error("write without data");
   a_readback_window: assert property (dev_oe |->
      !$past(sel_n, 2) && $past(wr_n, 2))
      else $error("device drives outside readback");
   a_busy_on_rise: assert property ($changed(busy) |->
      $past(cfg_clk, 3) && !$past(cfg_clk, 4))
      else $error("busy moved off clock rise");
endmodule // pcp_monitor

// File: test/test_byte_parallel_config_port.sv
`timescale 1ns/1ps
module test_byte_parallel_config_port;
   logic        clk = 0, rst = 1, wv = 0, rq = 0, rs_n = 1, ret = 1;
   logic [2:0]  mode = 3'h0;
   logic [7:0]  wd = 8'h00, rb = 8'h00, bo, rd;
   logic        ms, bv, done, act, rdy, rv, ab2;
   logic [11:0] rows [8] = '{12'h14B, 12'h2B4, 12'h402, 12'h700,
                             12'h9FF, 12'hA00, 12'hC78, 12'hF86};
   int          errors = 0, cmp_count = 0, na = 0, cyc = 0;
   pcp_if u_if ();
   pcp_if u_if2 ();
   always #12.5 clk = ~clk;
   pcp_device #(.PKT_LEN(8)) u_pcp_device (.CORE_CLK_IN(clk), .RST_IN(rst),
      .port(u_if.device), .RESTART_N_IN(rs_n), .MODE_SELECT_PINS_IN(mode),
      .RETAIN_IN(ret), .RB_DATA_IN(rb), .MASTER_SERIAL_OUT(ms),
      .BYTE_VALID_OUT(bv), .BYTE_OUT(bo), .ABORT_OUT(), .DONE_OUT(done),
      .PORT_ACTIVE_OUT(act));
   pcp_device u_pcp_device_2 (.CORE_CLK_IN(clk), .RST_IN(rst),
      .port(u_if2.device), .RESTART_N_IN(1'b1), .MODE_SELECT_PINS_IN(mode),
      .RETAIN_IN(ret), .RB_DATA_IN(rb), .MASTER_SERIAL_OUT(),
      .BYTE_VALID_OUT(), .BYTE_OUT(), .ABORT_OUT(ab2), .DONE_OUT(),
      .PORT_ACTIVE_OUT());
   pcp_host u_pcp_host (.CORE_CLK_IN(clk), .RST_IN(rst), .port(u_if.host),
      .WR_VALID_IN(wv), .WR_DATA_IN(wd), .WR_READY_OUT(rdy),
      .RD_REQ_IN(rq), .RD_VALID_OUT(rv), .RD_DATA_OUT(rd));
   pcp_monitor u_pcp_monitor (.CORE_CLK_IN(clk), .RST_IN(rst),
      .cfg_clk(u_if.cfg_clk), .sel_n(u_if.sel_n), .wr_n(u_if.wr_n),
      .host_d(u_if.host_d), .host_oe(u_if.host_oe),
      .dev_oe(u_if.dev_oe), .busy(u_if.busy));
   always @(posedge clk) begin
      na += (ab2 === 1'b1);
      if (++cyc == 20000) begin
         errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] d);
      wv = 1;
      wd = d;
      for (int n = 0; n < 400 && rdy !== 1'b1; n++) step(1);
      step(1);
      wv = 0;
      for (int n = 0; n < 400 && bv !== 1'b1; n++) step(1);
   endtask
   task automatic tk2();
      step(4);
      u_if2.cfg_clk = 1;
      step(4);
      u_if2.cfg_clk = 0;
   endtask
   initial begin
      {u_if2.cfg_clk, u_if2.sel_n, u_if2.wr_n, u_if2.host_oe} = 4'h6;
      u_if2.host_d = 8'h12;
      step(4);
      rst = 0;
      step(2);
      chk({6'h00, u_if.busy, u_if.dev_oe}, 8'h00);
      for (int i = 0; i < 8; i++) begin
         mode = rows[i][11:9];
         wr(rows[i][8:1]);
         chk(bo, rows[i][8:1]);
         chk({7'h00, ms}, {7'h00, rows[i][0]});
      end
      chk({6'h00, done, act}, 8'h03);
      rb = 8'h69;
      rq = 1;
      for (int n = 0; n < 400 && rv !== 1'b1; n++) step(1);
      rq = 0;
      chk(rd, 8'h69);
      ret = 0;
      step(4);
      chk({7'h00, act}, 8'h00);
      rs_n = 0;
      step(8);
      chk({7'h00, done}, 8'h00);
      wr(8'h77);
      chk(bo, 8'hC3);
      rs_n = 1;
      wr(8'h3E);
      chk(bo, 8'h3E);
      step(8);
      chk({7'h00, u_if.sel_n}, 8'h01);
      {u_if2.sel_n, u_if2.wr_n, u_if2.host_oe} = 3'h1;
      tk2();
      {u_if2.wr_n, u_if2.host_oe} = 2'h2;
      tk2();
      tk2();
      chk(na[7:0], 8'h01);
      summarize();
   end
endmodule // test_byte_parallel_config_port
